/* hw/bfs_pkg.sv */
// Constants, register map, state encodings and timing tables for the backlight fade sequencer
// Overview of operation
// - Level select 00 takes peak and low codes from registers 0x05 and 0x06.
// - Level select 01 takes peak and low codes from registers 0x07 and 0x08.
// - Level select 10 takes peak and low codes from registers 0x09 and 0x0A.
// - Every peak and low code is seven bits, 128 sink levels.
// - Linear law gives current equal to code times full scale over 127.
// - Square law gives current equal to (code times root full scale over 127) squared.
// - With normal run set, backlight on bit switches the backlight on and off.
// - While on, dim request picks low code, otherwise peak code.
// - Low and peak codes are applied as written, never clamped.
// - Dim delay counts from turn-on and then sets dim request itself.
// - Clearing dim request or reasserting on restores peak and restarts dim countdown.
// - Off delay counts from turn-on and then clears backlight on itself.
// - Reasserting on restarts off countdown; clearing on turns off at once.
// - With both delays and off delay longer than dim delay, sequence runs peak, then low, then off.
// - Fade-up time covers off to low, off to peak and low to peak.
// - Fade-up time is a full-scale rise; partial rises take proportionally less.
// - Fade-down time covers peak to low and low to off.
// - Fade-down time is a full-scale fall; partial falls take proportionally less.
// - Fades ramp up to peak, down to low, down to zero.
// - Asserting on during a fade-down turns the ramp upward from present code.
// - Fade-up and fade-down are independent and combine with both delays.
// - With fade bypass set, reasserting on during a fade jumps to peak.
package bfs_pkg;
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int HZ_PER_MHZ = 1_000_000;
  localparam int CYC_PER_US = CLK_FREQ_HZ / HZ_PER_MHZ;
  localparam int US_PER_MS = 1000;
  localparam int MS_PER_S = 1000;
  localparam int CODE_FULL = 127;

  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_CONFIG = 8'h02;
  localparam logic [7:0] REG_DELAY = 8'h03;
  localparam logic [7:0] REG_FADE = 8'h04;
  localparam logic [7:0] REG_L1_PEAK = 8'h05;
  localparam int LEVELS = 3;

  localparam int MODE_RUN_BIT = 0;
  localparam int MODE_ON_BIT = 1;
  localparam int MODE_DIM_BIT = 2;
  localparam int MODE_RISE_BIT = 6;
  localparam int MODE_FALL_BIT = 7;
  localparam int CFG_LVL_LSB = 0;
  localparam int CFG_BYPASS_BIT = 2;
  localparam int CFG_LAW_LSB = 4;
  localparam int NIB_HI_LSB = 4;

  localparam logic [1:0] LVL_DAY = 2'h0;
  localparam logic [1:0] LVL_OFFICE = 2'h1;
  localparam logic [1:0] LVL_DARK = 2'h2;
  localparam logic [1:0] LAW_LINEAR = 2'h0;
  localparam logic [1:0] LAW_SQUARE = 2'h1;
  localparam logic [3:0] TIME_OFF = 4'h0;
  localparam logic [6:0] CODE_ZERO = 7'h00;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_PTR = 2'h1;
  localparam logic [1:0] PH_DATA = 2'h2;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
  localparam logic [3:0] I2C_LAST_BIT = 4'h7;

  typedef enum logic [2:0] {
    SEQ_HOLD = 3'b001,
    SEQ_RISE = 3'b010,
    SEQ_FALL = 3'b100
  } bfs_seq_type;

  typedef enum logic [4:0] {
    I2C_IDLE = 5'b00001,
    I2C_RECV = 5'b00010,
    I2C_ACK = 5'b00100,
    I2C_SEND = 5'b01000,
    I2C_RACK = 5'b10000
  } bfs_i2c_type;

  // Dim and off delay in milliseconds for each nonzero setting
  function automatic logic [16:0] delay_ms(input logic [3:0] sel);
    logic [6:0] s;
    case (sel)
      4'h1: s = 7'h0A;
      4'h2: s = 7'h0F;
      4'h3: s = 7'h14;
      4'h4: s = 7'h19;
      4'h5: s = 7'h1E;
      4'h6: s = 7'h28;
      4'h7: s = 7'h32;
      4'h8: s = 7'h3C;
      4'h9: s = 7'h46;
      4'hA: s = 7'h50;
      4'hB: s = 7'h5A;
      4'hC: s = 7'h64;
      4'hD: s = 7'h69;
      4'hE: s = 7'h6E;
      default: s = 7'h78;
    endcase
    return 17'(s * MS_PER_S);
  endfunction

  // Microseconds per one-code fade step: full-scale time over 127
  function automatic logic [15:0] fade_step_us(input logic [3:0] sel);
    logic [12:0] ms;
    case (sel)
      4'h1: ms = 13'h012C;
      4'h2: ms = 13'h0258;
      4'h3: ms = 13'h0384;
      4'h4: ms = 13'h04B0;
      4'h5: ms = 13'h05DC;
      4'h6: ms = 13'h0708;
      4'h7: ms = 13'h0834;
      4'h8: ms = 13'h0960;
      4'h9: ms = 13'h0A8C;
      4'hA: ms = 13'h0BB8;
      4'hB: ms = 13'h0DAC;
      4'hC: ms = 13'h0FA0;
      4'hD: ms = 13'h1194;
      4'hE: ms = 13'h1388;
      default: ms = 13'h157C;
    endcase
    return 16'((ms * US_PER_MS) / CODE_FULL);
  endfunction
endpackage

/* hw/bfs_sink_law.sv */
// Maps the sink code to a relative sink current under the selected law
module bfs_sink_law (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Code and law
  input wire logic [6:0] code,
  input wire logic [1:0] law,
  // Current in units of full scale / 16129
  output logic [13:0] level
);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level <= 14'h0000;
    end else if (law == bfs_pkg::LAW_LINEAR) begin
      level <= 14'(code * bfs_pkg::CODE_FULL);
    end else begin
      // square law; law settings 2 and 3 also take this branch
      level <= 14'(code * code);
    end
  end

  property p_linear;
    @(posedge sys_clk) disable iff (rst)
    ($past(law) == bfs_pkg::LAW_LINEAR) |-> (level == 14'($past(code) * bfs_pkg::CODE_FULL));
  endproperty
  linear_law_a: assert property (p_linear) else $error("linear law level wrong");

  property p_square;
    @(posedge sys_clk) disable iff (rst)
    ($past(law) == bfs_pkg::LAW_SQUARE) |-> (level == 14'($past(code) * $past(code)));
  endproperty
  square_law_a: assert property (p_square) else $error("square law level wrong");
endmodule

/* hw/bfs_fade_top.sv */
// Backlight fade sequencer with its register port
module bfs_fade_top #(
  parameter int US_CYCLES = bfs_pkg::CYC_PER_US,
  parameter int US_PER_MS_P = bfs_pkg::US_PER_MS,
  // Bus address; value is arbitrary
  parameter logic [6:0] DEV_ADDR = 7'h2C
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial register port
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Current sink
  output logic [6:0] sink_code,
  output logic [13:0] sink_level
);
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  bfs_pkg::bfs_i2c_type i_state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg, tx, ptr, rd_data;
  logic [1:0] phase;
  logic rw, nack;
  logic wr_en;

  logic normal_run, backlight_on, dim_request, fade_bypass;
  logic [1:0] level_select, brightness_law;
  logic [3:0] dim_delay, off_delay, fade_up_time, fade_down_time;
  logic [6:0] peak_code [bfs_pkg::LEVELS];
  logic [6:0] low_code [bfs_pkg::LEVELS];
  logic [6:0] peak_sel, low_sel, target;

  logic mode_wr, on_wr1, dim_clr_wr, active;
  logic [11:0] us_cnt;
  logic [9:0] ms_cnt;
  logic us_tick, ms_tick;
  logic [16:0] dim_cnt, off_cnt;
  logic dim_expire, off_expire;
  bfs_pkg::bfs_seq_type seq_state;
  logic [6:0] code_now;
  logic [15:0] step_cnt, step_lim;
  logic step_tick, bypass_jump;

  // Port pins are synchronous; one stage gives the edge history
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end
  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign bus_start = scl & scl_q & sda_q & ~sda_in;
  assign bus_stop = scl & scl_q & ~sda_q & sda_in;
  assign wr_en = (i_state == bfs_pkg::I2C_RECV) && scl_fall
    && (bit_cnt == bfs_pkg::I2C_BYTE_BITS) && (phase == bfs_pkg::PH_DATA);

  // Serial slave: address, register pointer, then auto-incremented data
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      i_state <= bfs_pkg::I2C_IDLE;
      bit_cnt <= 4'h0;
      shreg <= bfs_pkg::REG_RESET;
      tx <= bfs_pkg::REG_RESET;
      ptr <= bfs_pkg::REG_RESET;
      phase <= bfs_pkg::PH_ADDR;
      rw <= 1'b0;
      nack <= 1'b0;
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
    end else if (bus_start) begin
      i_state <= bfs_pkg::I2C_RECV;
      bit_cnt <= 4'h0;
      phase <= bfs_pkg::PH_ADDR;
      sda_oe_n <= 1'b1;
    end else if (bus_stop) begin
      i_state <= bfs_pkg::I2C_IDLE;
      sda_oe_n <= 1'b1;
    end else begin
      case (i_state)
        bfs_pkg::I2C_RECV: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_in};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == bfs_pkg::I2C_BYTE_BITS) begin
            bit_cnt <= 4'h0;
            if (phase == bfs_pkg::PH_ADDR && shreg[7:1] != DEV_ADDR) begin
              i_state <= bfs_pkg::I2C_IDLE;
            end else begin
              sda_oe_n <= 1'b0;
              i_state <= bfs_pkg::I2C_ACK;
              if (phase == bfs_pkg::PH_ADDR) begin
                rw <= shreg[0];
              end else if (phase == bfs_pkg::PH_PTR) begin
                ptr <= shreg;
              end else begin
                ptr <= ptr + 8'h01;
              end
            end
          end
        end
        bfs_pkg::I2C_ACK: begin
          if (scl_fall) begin
            if (rw) begin
              tx <= rd_data;
              ptr <= ptr + 8'h01;
              sda_oe_n <= rd_data[7];
              i_state <= bfs_pkg::I2C_SEND;
            end else begin
              sda_oe_n <= 1'b1;
              i_state <= bfs_pkg::I2C_RECV;
              if (phase != bfs_pkg::PH_DATA) begin
                phase <= phase + 2'h1;
              end
            end
          end
        end
        bfs_pkg::I2C_SEND: begin
          if (scl_fall) begin
            if (bit_cnt == bfs_pkg::I2C_LAST_BIT) begin
              bit_cnt <= 4'h0;
              sda_oe_n <= 1'b1;
              i_state <= bfs_pkg::I2C_RACK;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
              tx <= {tx[6:0], 1'b0};
              sda_oe_n <= tx[6];
            end
          end
        end
        bfs_pkg::I2C_RACK: begin
          if (scl_rise) begin
            nack <= sda_in;
          end else if (scl_fall) begin
            if (nack) begin
              i_state <= bfs_pkg::I2C_IDLE;
            end else begin
              tx <= rd_data;
              ptr <= ptr + 8'h01;
              sda_oe_n <= rd_data[7];
              i_state <= bfs_pkg::I2C_SEND;
            end
          end
        end
        default: begin
          i_state <= bfs_pkg::I2C_IDLE;
        end
      endcase
    end
  end

  // Read-back; mode register also shows the ramp direction
  always_comb begin
    rd_data = bfs_pkg::REG_RESET;
    if (ptr == bfs_pkg::REG_MODE) begin
      rd_data[bfs_pkg::MODE_RUN_BIT] = normal_run;
      rd_data[bfs_pkg::MODE_ON_BIT] = backlight_on;
      rd_data[bfs_pkg::MODE_DIM_BIT] = dim_request;
      rd_data[bfs_pkg::MODE_RISE_BIT] = (seq_state == bfs_pkg::SEQ_RISE);
      rd_data[bfs_pkg::MODE_FALL_BIT] = (seq_state == bfs_pkg::SEQ_FALL);
    end else if (ptr == bfs_pkg::REG_CONFIG) begin
      rd_data[bfs_pkg::CFG_LVL_LSB +: 2] = level_select;
      rd_data[bfs_pkg::CFG_BYPASS_BIT] = fade_bypass;
      rd_data[bfs_pkg::CFG_LAW_LSB +: 2] = brightness_law;
    end else if (ptr == bfs_pkg::REG_DELAY) begin
      rd_data = {off_delay, dim_delay};
    end else if (ptr == bfs_pkg::REG_FADE) begin
      rd_data = {fade_down_time, fade_up_time};
    end else begin
      for (int i = 0; i < bfs_pkg::LEVELS; i++) begin
        if (ptr == 8'(bfs_pkg::REG_L1_PEAK + 2 * i)) begin
          rd_data = {1'b0, peak_code[i]};
        end else if (ptr == 8'(bfs_pkg::REG_L1_PEAK + 2 * i + 1)) begin
          rd_data = {1'b0, low_code[i]};
        end
      end
    end
  end

  assign mode_wr = wr_en && (ptr == bfs_pkg::REG_MODE);
  assign on_wr1 = mode_wr && shreg[bfs_pkg::MODE_ON_BIT];
  assign dim_clr_wr = mode_wr && !shreg[bfs_pkg::MODE_DIM_BIT] && dim_request;
  assign active = normal_run && backlight_on;

  // Mode bits; a hardware set of the dim request wins over a write that leaves on clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      normal_run <= 1'b0;
      backlight_on <= 1'b0;
      dim_request <= 1'b0;
    end else begin
      if (mode_wr) begin
        normal_run <= shreg[bfs_pkg::MODE_RUN_BIT];
      end
      // software switches the backlight; off expiry clears it
      if (mode_wr) begin
        backlight_on <= shreg[bfs_pkg::MODE_ON_BIT];
      end else if (off_expire) begin
        backlight_on <= 1'b0;
      end
      // dim expiry sets the request itself
      if (dim_expire) begin
        dim_request <= 1'b1;
      end else if (mode_wr) begin
        dim_request <= shreg[bfs_pkg::MODE_DIM_BIT];
      end else if (off_expire) begin
        dim_request <= 1'b0;
      end
    end
  end

  // Configuration and timing fields
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level_select <= bfs_pkg::LVL_DAY;
      fade_bypass <= 1'b0;
      brightness_law <= bfs_pkg::LAW_LINEAR;
      dim_delay <= bfs_pkg::TIME_OFF;
      off_delay <= bfs_pkg::TIME_OFF;
      fade_up_time <= bfs_pkg::TIME_OFF;
      fade_down_time <= bfs_pkg::TIME_OFF;
    end else if (wr_en) begin
      if (ptr == bfs_pkg::REG_CONFIG) begin
        level_select <= shreg[bfs_pkg::CFG_LVL_LSB +: 2];
        fade_bypass <= shreg[bfs_pkg::CFG_BYPASS_BIT];
        brightness_law <= shreg[bfs_pkg::CFG_LAW_LSB +: 2];
      end else if (ptr == bfs_pkg::REG_DELAY) begin
        dim_delay <= shreg[3:0];
        off_delay <= shreg[bfs_pkg::NIB_HI_LSB +: 4];
      end else if (ptr == bfs_pkg::REG_FADE) begin
        fade_up_time <= shreg[3:0];
        fade_down_time <= shreg[bfs_pkg::NIB_HI_LSB +: 4];
      end
    end
  end

  // seven-bit codes, one pair per level
  for (genvar g = 0; g < bfs_pkg::LEVELS; g++) begin : g_level
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        peak_code[g] <= bfs_pkg::CODE_ZERO;
        low_code[g] <= bfs_pkg::CODE_ZERO;
      end else if (wr_en && ptr == 8'(bfs_pkg::REG_L1_PEAK + 2 * g)) begin
        peak_code[g] <= shreg[6:0];
      end else if (wr_en && ptr == 8'(bfs_pkg::REG_L1_PEAK + 2 * g + 1)) begin
        low_code[g] <= shreg[6:0];
      end
    end
  end

  // daylight pair; office pair; dark pair, also for 11
  always_comb begin
    if (level_select == bfs_pkg::LVL_DAY) begin
      peak_sel = peak_code[0];
      low_sel = low_code[0];
    end else if (level_select == bfs_pkg::LVL_OFFICE) begin
      peak_sel = peak_code[1];
      low_sel = low_code[1];
    end else begin
      peak_sel = peak_code[2];
      low_sel = low_code[2];
    end
  end

  // pick code; no clamp, a low code above peak is honoured
  assign target = !active ? bfs_pkg::CODE_ZERO : (dim_request ? low_sel : peak_sel);

  // Microsecond and millisecond enables from the core clock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      us_cnt <= 12'h000;
      ms_cnt <= 10'h000;
    end else begin
      us_cnt <= us_tick ? 12'h000 : us_cnt + 12'h001;
      if (us_tick) begin
        ms_cnt <= ms_tick ? 10'h000 : ms_cnt + 10'h001;
      end
    end
  end
  assign us_tick = (us_cnt == 12'(US_CYCLES - 1));
  assign ms_tick = us_tick && (ms_cnt == 10'(US_PER_MS_P - 1));

  // dim countdown from turn-on; zero setting disables it
  assign dim_expire = active && !dim_request && dim_delay != bfs_pkg::TIME_OFF && ms_tick
    && !on_wr1 && (dim_cnt >= bfs_pkg::delay_ms(dim_delay) - 17'h00001);
  assign off_expire = active && off_delay != bfs_pkg::TIME_OFF && ms_tick && !mode_wr
    && (off_cnt >= bfs_pkg::delay_ms(off_delay) - 17'h00001);

  // clear of dim or reassert restarts; both timers run together
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dim_cnt <= 17'h00000;
    end else if (!active || dim_request || on_wr1 || dim_clr_wr || dim_expire) begin
      dim_cnt <= 17'h00000;
    end else if (ms_tick) begin
      dim_cnt <= dim_cnt + 17'h00001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      off_cnt <= 17'h00000;
    end else if (!active || on_wr1 || off_expire) begin
      off_cnt <= 17'h00000;
    end else if (ms_tick) begin
      off_cnt <= off_cnt + 17'h00001;
    end
  end

  // step is full-scale time over 127; partial rise or fall is shorter
  assign step_lim = (seq_state == bfs_pkg::SEQ_RISE) ? bfs_pkg::fade_step_us(fade_up_time)
    : bfs_pkg::fade_step_us(fade_down_time);
  assign step_tick = (seq_state != bfs_pkg::SEQ_HOLD) && us_tick
    && (step_cnt >= step_lim - 16'h0001);
  // bypass jumps straight to peak when on is reasserted mid-fade
  assign bypass_jump = on_wr1 && fade_bypass && (seq_state != bfs_pkg::SEQ_HOLD);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      step_cnt <= 16'h0000;
    end else if (seq_state == bfs_pkg::SEQ_HOLD || step_tick) begin
      step_cnt <= 16'h0000;
    end else if (us_tick) begin
      step_cnt <= step_cnt + 16'h0001;
    end
  end

  // Ramp engine; a direction change starts from the present code
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      seq_state <= bfs_pkg::SEQ_HOLD;
      code_now <= bfs_pkg::CODE_ZERO;
    end else if (bypass_jump) begin
      seq_state <= bfs_pkg::SEQ_HOLD;
      code_now <= peak_sel;
    end else if (code_now < target) begin
      // rising transitions; zero fade-up is immediate
      if (fade_up_time == bfs_pkg::TIME_OFF) begin
        seq_state <= bfs_pkg::SEQ_HOLD;
        code_now <= target;
      end else begin
        // ramp up; a fall turns upward here
        seq_state <= bfs_pkg::SEQ_RISE;
        if (seq_state == bfs_pkg::SEQ_RISE && step_tick) begin
          code_now <= code_now + 7'h01;
        end
      end
    end else if (code_now > target) begin
      // falling transitions; each direction has its own setting
      if (fade_down_time == bfs_pkg::TIME_OFF) begin
        seq_state <= bfs_pkg::SEQ_HOLD;
        code_now <= target;
      end else begin
        seq_state <= bfs_pkg::SEQ_FALL;
        if (seq_state == bfs_pkg::SEQ_FALL && step_tick) begin
          code_now <= code_now - 7'h01;
        end
      end
    end else begin
      seq_state <= bfs_pkg::SEQ_HOLD;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sink_code <= bfs_pkg::CODE_ZERO;
    end else begin
      sink_code <= code_now;
    end
  end

  bfs_sink_law u_law (
    .sys_clk(sys_clk),
    .rst(rst),
    .code(sink_code),
    .law(brightness_law),
    .level(sink_level)
  );

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  lvl_decode_a: assert property (level_select == bfs_pkg::LVL_OFFICE |->
    peak_sel == peak_code[1] && low_sel == low_code[1]) else $error("level decode wrong");
  day_decode_a: assert property (level_select == bfs_pkg::LVL_DAY |->
    peak_sel == peak_code[0] && low_sel == low_code[0]) else $error("daylight decode wrong");
  dim_expire_a: assert property (dim_expire |=> dim_request)
    else $error("dim request not set on expiry");
  off_expire_a: assert property (off_expire |=> !backlight_on && !active)
    else $error("backlight still on after off expiry");
  sequence s_restart;
    on_wr1 ##1 1'b1;
  endsequence
  off_restart_a: assert property (s_restart |-> off_cnt == 17'h00000)
    else $error("off countdown not restarted");
  dim_restart_a: assert property (dim_clr_wr |=> dim_cnt == 17'h00000 && !dim_request)
    else $error("dim countdown not restarted");
  step_up_a: assert property (seq_state == bfs_pkg::SEQ_RISE && step_tick && !bypass_jump
    && code_now < target |=> code_now == $past(code_now) + 7'h01) else $error("bad up step");
  bypass_jump_a: assert property (bypass_jump |=> code_now == $past(peak_sel))
    else $error("bypass did not jump to peak");
  no_fade_up_a: assert property (!bypass_jump && code_now < target
    && fade_up_time == bfs_pkg::TIME_OFF |=> code_now == $past(target))
    else $error("zero fade-up not immediate");
endmodule

/* tb/bfs_host_model.sv */
// Serial bus master model that reaches the sequencer registers
module bfs_host_model (
  // Clock and wire level
  input wire logic sys_clk,
  input wire logic sda_line,
  // Master drive; sda_drv released high through the pull-up, scl driven directly
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Data moves only while scl is low; sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_drv <= b;
    tick(2);
    scl <= 1'b1;
    tick(3);
    r = sda_line;
    tick(1);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic start();
    sda_drv <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b1;
    tick(4);
  endtask
  // MSB first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
                         output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(last, ack);
  endtask
endmodule

/* tb/tb_backlight_fade_sequencer.sv */
// Register-level bench for the backlight fade sequencer
module tb_backlight_fade_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] ADDR = 7'h2C;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_drv, sda_out, sda_oe_n, sda_line, ack;
  logic [6:0] sink_code;
  logic [13:0] sink_level;
  logic [7:0] q;
  int num_errors = 0;
  int cmp_count = 0;
  logic [7:0] cd [6] = '{8'hC0, 8'h10, 8'h30, 8'h7F, 8'h05, 8'h7E};
  logic [7:0] sp [7] = '{8'h00, 8'h02, 8'h02, 8'h00, 8'h02, 8'h00, 8'h00};
  logic [7:0] sd [7] = '{8'h03, 8'h01, 8'h02, 8'h07, 8'h01, 8'h03, 8'h01};
  logic [6:0] sc [7] = '{7'h40, 7'h30, 7'h05, 7'h7E, 7'h7F, 7'h30, 7'h00};
  // Open-drain wire with pull-up
  assign sda_line = sda_drv & (sda_oe_n | sda_out);
  bfs_fade_top #(.US_CYCLES(1), .US_PER_MS_P(1), .DEV_ADDR(ADDR)) u_bfs_fade_top (
    .sys_clk(sys_clk), .rst(rst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .sink_code(sink_code), .sink_level(sink_level));
  bfs_host_model host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_sink(input string what, input logic [13:0] exp, input logic [13:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] x;
    host.start();
    host.byte_io({ADDR, 1'b0}, 1'b1, x, ack);
    chk_reg("address ack", 8'h00, {7'h00, ack});
    host.byte_io(p, 1'b1, x, ack);
    host.byte_io(d, 1'b1, x, ack);
    chk_reg("data ack", 8'h00, {7'h00, ack});
    host.stop();
    host.tick(4);
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] x;
    logic a;
    host.start();
    host.byte_io({ADDR, 1'b0}, 1'b1, x, a);
    host.byte_io(p, 1'b1, x, a);
    host.start();
    host.byte_io({ADDR, 1'b1}, 1'b1, x, a);
    host.byte_io(8'hFF, 1'b1, d, a);
    host.stop();
    host.tick(4);
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Whole run needs about 45000 cycles, most of it waiting on the timers
  initial begin
    repeat (90000) @(posedge sys_clk);
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    host.tick(2);
    chk_sink("code after reset", 14'h0000, {7'h00, sink_code});
    for (int p = 0; p <= 10; p++) begin
      rd(8'(p), q);
      chk_reg("reset value", 8'h00, q);
    end
    // Foreign address must stay unanswered
    host.start();
    host.byte_io({ADDR ^ 7'h01, 1'b0}, 1'b1, q, ack);
    chk_reg("foreign ack", 8'h01, {7'h00, ack});
    host.stop();
    wr(8'h01, 8'hFF);
    rd(8'h01, q);
    chk_reg("unmapped", 8'h00, q);
    for (int i = 0; i < 6; i++) begin
      wr(8'(i + 5), cd[i]);
    end
    for (int i = 0; i < 6; i++) begin
      rd(8'(i + 5), q);
      chk_reg("code reg", cd[i] & 8'h7F, q);
    end
    for (int i = 0; i < 7; i++) begin
      wr(sp[i], sd[i]);
      chk_sink("sink code", {7'h00, sc[i]}, {7'h00, sink_code});
      chk_sink("linear level", 14'(sc[i]) * 14'h007F, sink_level);
    end
    wr(8'h00, 8'h03);
    wr(8'h02, 8'h11);
    chk_sink("square level", 14'h0900, sink_level);
    wr(8'h02, 8'h01);
    wr(8'h00, 8'h01);
    // Fade-up only: ramp flagged, fall stays immediate
    wr(8'h04, 8'h01);
    wr(8'h00, 8'h03);
    rd(8'h00, q);
    chk_reg("rising mode", 8'h43, q);
    host.tick(5000);
    chk_sink("two steps up", 14'h0002, {7'h00, sink_code});
    wr(8'h00, 8'h01);
    chk_sink("off without fade", 14'h0000, {7'h00, sink_code});
    // Dim and off timers: a reassert restarts both, then peak, low, off
    wr(8'h02, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h03, 8'h21);
    wr(8'h00, 8'h03);
    chk_sink("timer peak", 14'h0040, {7'h00, sink_code});
    host.tick(5000);
    wr(8'h00, 8'h03);
    host.tick(7000);
    chk_sink("restarted peak", 14'h0040, {7'h00, sink_code});
    host.tick(5000);
    chk_sink("timed dim", 14'h0010, {7'h00, sink_code});
    host.tick(5000);
    chk_sink("timed off", 14'h0000, {7'h00, sink_code});
    rd(8'h00, q);
    chk_reg("on cleared", 8'h01, q);
    // Fall, turn upward mid-fall, then bypass jumps to peak
    wr(8'h03, 8'h00);
    wr(8'h00, 8'h03);
    wr(8'h04, 8'h11);
    wr(8'h00, 8'h01);
    rd(8'h00, q);
    chk_reg("falling mode", 8'h81, q);
    host.tick(2500);
    chk_sink("one step down", 14'h003F, {7'h00, sink_code});
    wr(8'h00, 8'h03);
    rd(8'h00, q);
    chk_reg("turned upward", 8'h43, q);
    wr(8'h02, 8'h04);
    wr(8'h00, 8'h03);
    chk_sink("bypass peak", 14'h0040, {7'h00, sink_code});
    end_of_test();
  end
endmodule
